// ### hdl/tcio_top.v
`timescale 1ns/1ns
`include "tcio_consts.vh"
// slot 0 is the ch0 C register, slots 1 to 3 the A registers of ch1..ch3
module tcio_top #(
  parameter CW = 16
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // counter values of the channels, same clock
  input wire [CW-1:0] ch0_counter,
  input wire [CW-1:0] ch1_counter,
  input wire [CW-1:0] ch2_counter,
  input wire [CW-1:0] ch3_counter,
  // chained trigger pulses from neighbouring channels
  input wire ch1_count_pulse,
  input wire ch4_count_pulse,
  input wire ch0_a_event,
  // pin levels in, levels out and active-low output enables
  input wire ch0_pin_c_i,
  output wire ch0_pin_c_o,
  output wire ch0_pin_c_oe_n,
  input wire ch1_pin_a_i,
  output wire ch1_pin_a_o,
  output wire ch1_pin_a_oe_n,
  input wire ch2_pin_a_i,
  output wire ch2_pin_a_o,
  output wire ch2_pin_a_oe_n,
  input wire ch3_pin_a_i,
  output wire ch3_pin_a_o,
  output wire ch3_pin_a_oe_n,
  // per-slot capture or match pulse
  output wire [3:0] chan_event
);
  localparam NCH = 4;
  // slot numbers two bits per slot, chain support one bit per slot
  localparam [7:0] SLOT_IDS = `TCIO_SLOT_IDS;
  localparam [3:0] CHAIN_EN = `TCIO_CHAIN_EN;

  // address is word aligned and lands on a mapped register
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'b00) &&
                (a[7:4] == `TCIO_MODE_PAGE || a[7:4] == `TCIO_GR_PAGE ||
                 a == `TCIO_OFF_CH0MODE || a == `TCIO_OFF_PINSTAT);
    end
  endfunction

  // pick one four-bit field out of the packed mode vector
  function [3:0] pick4;
    input [15:0] v;
    input [1:0] s;
    begin
      case (s)
        2'd0: pick4 = v[3:0];
        2'd1: pick4 = v[7:4];
        2'd2: pick4 = v[11:8];
        default: pick4 = v[15:12];
      endcase
    end
  endfunction

  // pick one general register out of the packed vector
  function [CW-1:0] pick_gr;
    input [4*CW-1:0] v;
    input [1:0] s;
    begin
      case (s)
        2'd0: pick_gr = v[CW-1:0];
        2'd1: pick_gr = v[2*CW-1:CW];
        2'd2: pick_gr = v[3*CW-1:2*CW];
        default: pick_gr = v[4*CW-1:3*CW];
      endcase
    end
  endfunction

  // the pin takes part only when the low two field bits are not 00
  function out_on;
    input [3:0] m;
    begin
      out_on = (m[1:0] != 2'b00);
    end
  endfunction

  // apb handshake: zero wait states, but a frozen block holds the access
  wire access = psel & penable;
  wire good = addr_ok(paddr);
  wire wr_en = access & pwrite & good & clk_en;
  // a read whose setup edge fell while frozen waits one cycle for its data
  reg rd_held_reg;
  wire rd_load = psel & ~pwrite & ~(penable & rd_held_reg);
  assign pready = clk_en & (pwrite | rd_held_reg | ~access);
  assign pslverr = access & ~good;

  // set once the read data flop is filled, cleared when the read completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_held_reg <= 1'b0;
    end else if (clk_en) begin
      rd_held_reg <= rd_load;
    end
  end

  // address decode: page picks the register kind, slot the channel
  wire mode_page = (paddr[7:4] == `TCIO_MODE_PAGE);
  wire gr_page = (paddr[7:4] == `TCIO_GR_PAGE);
  wire [1:0] slot = paddr[3:2];

  // channel 0 mode register, only the buffer-operation bit is kept
  reg buffer_a_enable_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_a_enable_reg <= 1'b0;
    end else if (clk_en && wr_en && paddr == `TCIO_OFF_CH0MODE) begin
      buffer_a_enable_reg <= pwdata[`TCIO_BFA_BIT];
    end
  end

  // pin levels are foreign to pclk, so they pass two flops first
  wire [3:0] pin_raw = {ch3_pin_a_i, ch2_pin_a_i, ch1_pin_a_i, ch0_pin_c_i};
  wire [3:0] pin_sync;
  tcio_sync #(
    .W(NCH)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .d(pin_raw),
    .q_reg(pin_sync)
  );

  // per-channel inputs packed by slot
  wire [4*CW-1:0] cnt_all = {ch3_counter, ch2_counter, ch1_counter, ch0_counter};
  // chained triggers: slot 2 has none and never reads this bit
  wire [3:0] trig_all = {ch4_count_pulse, 1'b0, ch0_a_event, ch1_count_pulse};
  wire [3:0] inhibit_all = {3'b000, buffer_a_enable_reg};

  // packed per-slot views feed the read mux and the pin map
  wire [15:0] mode_all;
  wire [4*CW-1:0] gr_all;
  wire [3:0] pin_out;
  wire [3:0] oe_n_all;

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      // slot number and chain support of this slot
      localparam [1:0] IDX = SLOT_IDS[2*i +: 2];
      localparam CHAIN = CHAIN_EN[i];
      // per-slot field, general register and pin state
      reg [3:0] mode_reg;
      reg [CW-1:0] gr_reg;
      reg pin_reg;
      reg prev_reg;
      reg match_prev_reg;
      reg event_reg;
      // this slot's counter, pin and buffer inhibit
      wire [CW-1:0] cnt = cnt_all[i*CW +: CW];
      wire pin_in = pin_sync[i];
      wire inhibit = inhibit_all[i];
      // bus strobes aimed at this slot
      wire mode_wr = wr_en & mode_page & (slot == IDX);
      wire gr_wr = wr_en & gr_page & (slot == IDX);

      // capture mode and the chained source choice
      wire cap_mode = mode_reg[`TCIO_BIT_CAP] & ~inhibit;
      // slot 2 has no chained source, so bit 2 only sets the initial pin level there
      wire chained = (CHAIN != 0) & mode_reg[`TCIO_BIT_HI];
      wire rise = pin_in & ~prev_reg;
      wire fall = ~pin_in & prev_reg;
      reg edge_hit;

      // edge select on the channel's own pin
      always @* begin
        edge_hit = 1'b0;
        if (mode_reg[`TCIO_BIT_BOTH]) begin
          edge_hit = rise | fall;
        end else if (mode_reg[`TCIO_BIT_FALL]) begin
          edge_hit = fall;
        end else begin
          edge_hit = rise;
        end
      end

      wire cap_hit = cap_mode & (chained ? trig_all[i] : edge_hit);

      // compare is only armed with output on and no buffer use
      wire cmp_mode = ~mode_reg[`TCIO_BIT_CAP] & ~inhibit &
                      out_on(mode_reg);
      wire equal = (cnt == gr_reg);
      // first cycle of equality only, so a stalled counter toggles once
      wire cmp_hit = cmp_mode & equal & ~match_prev_reg;

      // output enable: capture mode or low bits 00 keep the pin released
      assign oe_n_all[i] = mode_reg[`TCIO_BIT_CAP] |
                           ~out_on(mode_reg);
      assign pin_out[i] = pin_reg;
      assign mode_all[i*4 +: 4] = mode_reg;
      assign gr_all[i*CW +: CW] = gr_reg;
      assign chan_event[i] = event_reg;

      // mode field; reset selects compare with output disabled
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode_reg <= `TCIO_MODE_RST;
        end else if (clk_en && mode_wr) begin
          mode_reg <= pwdata[`TCIO_MODE_W-1:0];
        end
      end

      // general register: capture wins over a software write in the same cycle
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gr_reg <= `TCIO_GR_RST;
        end else if (clk_en) begin
          if (cap_hit) begin
            gr_reg <= cnt;
          end else if (gr_wr) begin
            gr_reg <= pwdata[CW-1:0];
          end
        end
      end

      // pin level: initial level on a mode write, then compare actions
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_reg <= 1'b0;
        end else if (clk_en) begin
          if (mode_wr) begin
            pin_reg <= pwdata[`TCIO_BIT_HI];
          end else if (cmp_hit) begin
            case (mode_reg[1:0])
              2'b01: pin_reg <= 1'b0;
              2'b10: pin_reg <= 1'b1;
              2'b11: pin_reg <= ~pin_reg;
              default: pin_reg <= pin_reg;
            endcase
          end
        end
      end

      // edge history and one-cycle event pulse for neighbours
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prev_reg <= 1'b0;
          match_prev_reg <= 1'b0;
          event_reg <= 1'b0;
        end else if (clk_en) begin
          prev_reg <= pin_in;
          match_prev_reg <= equal;
          event_reg <= cap_hit | cmp_hit;
        end
      end
    end
  endgenerate

  assign ch0_pin_c_o = pin_out[0];
  assign ch1_pin_a_o = pin_out[1];
  assign ch2_pin_a_o = pin_out[2];
  assign ch3_pin_a_o = pin_out[3];

  // output enables, low while the pin is driven
  assign ch0_pin_c_oe_n = oe_n_all[0];
  assign ch1_pin_a_oe_n = oe_n_all[1];
  assign ch2_pin_a_oe_n = oe_n_all[2];
  assign ch3_pin_a_oe_n = oe_n_all[3];

  // read data is chosen in the setup cycle so prdata comes from a flop
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (mode_page) begin
      rd_next[3:0] = pick4(mode_all, slot);
    end else if (gr_page) begin
      rd_next[CW-1:0] = pick_gr(gr_all, slot);
    end else if (paddr == `TCIO_OFF_CH0MODE) begin
      rd_next[`TCIO_BFA_BIT] = buffer_a_enable_reg;
    end else if (paddr == `TCIO_OFF_PINSTAT) begin
      rd_next[11:0] = {oe_n_all, pin_out, pin_sync};
    end
    // unmapped or misaligned reads return zero
    if (!good) begin
      rd_next = 32'h00000000;
    end
  end

  // read data register, loaded at the setup edge of a read, or late if that edge was frozen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && rd_load) begin
      prdata <= rd_next;
    end
  end
endmodule // tcio_top

// ### hdl/tcio_consts.vh
`ifndef TCIO_CONSTS_VH
`define TCIO_CONSTS_VH

// address pages and single registers (byte addresses)
`define TCIO_MODE_PAGE 4'h0
`define TCIO_GR_PAGE 4'h2
`define TCIO_OFF_CH0MODE 8'h10
`define TCIO_OFF_PINSTAT 8'h14

// field layout of the four-bit mode field, and the buffer bit of the ch0 mode register
`define TCIO_MODE_W 4
`define TCIO_BIT_CAP 3
`define TCIO_BIT_HI 2
`define TCIO_BIT_BOTH 1
`define TCIO_BIT_FALL 0
`define TCIO_BFA_BIT 4

// reset values
`define TCIO_MODE_RST 4'h0
`define TCIO_GR_RST 16'hffff

// slot index of each channel, two bits per channel, and chain support
`define TCIO_SLOT_IDS 8'he4
`define TCIO_CHAIN_EN 4'hb
`endif

// ### hdl/tcio_sync.v
`timescale 1ns/1ns
// two-stage synchroniser for pin levels; first stage feeds only the second
module tcio_sync #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q_reg
);
  reg [W-1:0] meta_reg;

  // pins settle through two flops before any logic looks at them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q_reg <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
endmodule // tcio_sync

// ### sim/tcio_part.sv
`timescale 1ns/1ns
// neighbour channel: one shared counter, wrapping at 64 so that matches come round fast
module tcio_part (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire step,
  output reg [15:0] cnt_reg,
  output wire tick
);
  assign tick = run | step; // count pulse in every cycle the counter moves
  // counter advances while running or on a single step
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 16'h0000;
    else if (tick) cnt_reg <= (cnt_reg + 16'h0001) & 16'h003f;
  end
endmodule // tcio_part

// ### sim/tcio_chk.sv
`timescale 1ns/1ns
// mirrors mode writes, then ties pins and events to them
module tcio_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire ch1_count_pulse,
  input wire ch0_a_event,
  input wire ch1_pin_a_o,
  input wire ch1_pin_a_oe_n,
  input wire [3:0] chan_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg [3:0] m0_reg, m1_reg;
  reg bfa_reg;
  sequence s_wr;
    psel && penable && pwrite && pready;
  endsequence
  // mode mirror, taken on the same edge as the design's write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_reg <= 4'h0;
      m1_reg <= 4'h0;
      bfa_reg <= 1'b0;
    end else if (psel && penable && pwrite && pready) begin
      case (paddr)
        8'h00: m0_reg <= pwdata[3:0];
        8'h04: m1_reg <= pwdata[3:0];
        8'h10: bfa_reg <= pwdata[4];
        default: ;
      endcase
    end
  end
  a_bad_addr: assert property (psel && penable && paddr > 8'h2c |-> pslverr)
    else $error("unmapped access accepted");
  a_slv_idle: assert property (!penable |-> !pslverr)
    else $error("slverr outside access");
  a_oe_mode: assert property (ch1_pin_a_oe_n == (m1_reg[3] || m1_reg[1:0] == 2'h0))
    else $error("ch1 enable wrong");
  a_init_lvl: assert property (s_wr ##0 paddr == 8'h04 |=>
    ch1_pin_a_o == $past(pwdata[2])) else $error("ch1 start level wrong");
  a_chain_c: assert property (pready && &m0_reg[3:2] && !bfa_reg && ch1_count_pulse
    |=> chan_event[0]) else $error("ch0 chain missed");
  a_chain_one: assert property (pready && &m1_reg[3:2] && ch0_a_event |=> chan_event[1])
    else $error("ch1 chain missed");
  a_buf_quiet: assert property (bfa_reg |=> !chan_event[0])
    else $error("ch0 event in buffer mode");
  a_rst_quiet: assert property ($rose(presetn) |-> chan_event == 4'h0 && ch1_pin_a_oe_n)
    else $error("not quiet after reset");
endmodule // tcio_chk
bind tcio_top tcio_chk u_tcio_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .ch1_count_pulse, .ch0_a_event, .ch1_pin_a_o, .ch1_pin_a_oe_n, .chan_event);

// ### sim/tcio_top_test.sv
`timescale 1ns/1ns
module tcio_top_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic run = 0, step = 0, a_ev = 0, ce = 1, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic [3:0] pin = 4'h0, m;
  logic [15:0] v;
  wire [31:0] prdata;
  wire [15:0] cnt;
  wire [3:0] po, oe_n, ev;
  wire pready, tick;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  // one shared counter feeds every channel; pins are driven from here
  tcio_part u_tcio_part (.pclk, .presetn, .run, .step, .cnt_reg(cnt), .tick);
  tcio_top u_tcio_top (.pclk, .presetn, .clk_en(ce), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr(), .ch0_counter(cnt), .ch1_counter(cnt),
    .ch2_counter(cnt), .ch3_counter(cnt), .ch1_count_pulse(tick), .ch4_count_pulse(tick),
    .ch0_a_event(a_ev), .ch0_pin_c_i(pin[0]), .ch0_pin_c_o(po[0]), .ch0_pin_c_oe_n(oe_n[0]),
    .ch1_pin_a_i(pin[1]), .ch1_pin_a_o(po[1]), .ch1_pin_a_oe_n(oe_n[1]), .ch2_pin_a_i(pin[2]),
    .ch2_pin_a_o(po[2]), .ch2_pin_a_oe_n(oe_n[2]), .ch3_pin_a_i(pin[3]), .ch3_pin_a_o(po[3]),
    .ch3_pin_a_oe_n(oe_n[3]), .chan_event(ev));
  initial forever #5 pclk = ~pclk;
  // hang guard, far above the roughly one thousand cycles needed
  always @(posedge pclk) if (++cyc == 20000) begin
    error_cnt++;
    test_done;
  end
  task test_done;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(string n, logic [31:0] x, logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, x, g);
    end
  endtask
  // one transfer, held until pready is seen at an edge
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(logic [7:0] a, logic [31:0] x);
    apb(0, a, 32'h0);
    chk("read", x, q);
  endtask
  // stops at the first event, else looks n edges
  task wev(int i, int n, logic x);
    logic s;
    s = 0;
    repeat (n) if (!s) begin
      @(posedge pclk);
      s = ev[i];
    end
    chk("event", x, s);
  endtask
  task pulse(logic w);
    if (w) step <= 1;
    else a_ev <= 1;
    @(posedge pclk);
    step <= 0;
    a_ev <= 0;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0);
    rd(8'h14, 32'hf00);
    rd(8'h30, 32'h0);
    run <= 1;
    // every compare encoding on ch0 c, then ch1 a
    for (int k = 0; k < 16; k++) begin
      m = 4'(k % 8);
      apb(1, 8'(k / 8 * 4), {28'h0, m});
      chk("oe_n", m[1:0] == 2'h0, oe_n[k / 8]);
      if (m[1:0] != 2'h0) begin
        chk("init", m[2], po[k / 8]);
        apb(1, 8'(32 + k / 8 * 4), 32'h10);
        e = m[1:0] == 2'h1 ? 1'b0 : m[1:0] == 2'h2 | !m[2];
        wev(k / 8, 90, 1);
        chk("pin", e, po[k / 8]);
        apb(1, 8'(32 + k / 8 * 4), 32'hffff);
      end
    end
    run <= 0;
    // ch2 capture edges with the counter frozen
    for (int k = 0; k < 4; k++) begin
      m = k == 3 ? 4'hc : 4'(8 + k);
      apb(1, 8'h08, {28'h0, m});
      pulse(1);
      pin[2] <= 1;
      wev(2, 8, m[1:0] != 2'h1);
      if (m[1:0] != 2'h1) rd(8'h28, {16'h0, cnt});
      pin[2] <= 0;
      wev(2, 8, m[1:0] != 2'h0);
    end
    apb(1, 8'h00, 32'h8);
    pin[0] <= 1;
    wev(0, 8, 1);
    apb(1, 8'h00, 32'hc);
    v = cnt;
    pulse(1);
    wev(0, 4, 1);
    rd(8'h20, {16'h0, v});
    apb(1, 8'h0c, 32'hc);
    pulse(1);
    wev(3, 4, 1);
    apb(1, 8'h04, 32'hc);
    pulse(0);
    wev(1, 4, 1);
    apb(1, 8'h10, 32'h10);
    pulse(1);
    wev(0, 6, 0);
    rd(8'h10, 32'h10);
    // frozen: a count pulse is ignored, and a read set up while frozen gets fresh data
    ce <= 0;
    pulse(1);
    wev(3, 4, 0);
    fork
      apb(0, 8'h0c, 32'h0);
      begin
        @(posedge pclk);
        @(posedge pclk);
        ce <= 1;
      end
    join
    chk("frozen read", 32'hc, q);
    test_done;
  end
endmodule // tcio_top_test
